// ===== core/mcbd_branch_unit.sv
// conditional branch decode and program counter update with register slave
// What this block does
// - relative conditional jump taken: next address is current plus signed offset
// - offset is 5-bit two's complement, range minus sixteen to fifteen
// - codes 0 to 15 test flag low, 16 to 31 test flag high
// - codes 32 to 35 test terminal counts one to four
// - code 36 start low, 37 start high, 47 arithmetic request done
// - codes 38-40 vds low, 41-43 source low, 44-46 vds high
// - code 48 boost high, 49 boost low, current feedbacks high then low
// - code 62 own current feedback high, 63 own current feedback low
// - relative conditional jump: bits 15..11 zero, condition, offset lowest
// - absolute identifier jump loads counter from selected jump register
// - identifier select 0 means core zero, 1 means core one executing
// - absolute identifier jump pattern, selector bit 4, register bit 3
// - relative identifier jump adds signed offset when core matches
// - relative identifier jump pattern, selector bit 5, offset bits 4..0
`timescale 1ns/10ps
module mcbd_branch_unit (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         instr_valid,
  input  wire logic [mcbd_pkg::INSN_W-1:0]  instr_word,
  input  wire logic [15:0]                  flags,
  input  wire logic [3:0]                   terminal_count,
  input  wire logic                         start_in,
  input  wire logic [2:0]                   shortcut_vds_high,
  input  wire logic [2:0]                   shortcut_src_high,
  input  wire logic                         alu_op_done,
  input  wire logic                         boost_voltage_high,
  input  wire logic [5:0]                   current_fbk_high,
  input  wire logic                         own_current_high,
  input  wire logic                         core_zero_active,
  input  wire logic                         core_one_active,
  input  wire logic [mcbd_pkg::PC_W-1:0]    jump_register_set_0,
  input  wire logic [mcbd_pkg::PC_W-1:0]    jump_register_set_1,
  output logic      [mcbd_pkg::PC_W-1:0]    program_counter,
  output logic                              branch_taken,
  input  wire logic [mcbd_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [mcbd_pkg::DATA_W-1:0]  avs_writedata,
  output logic      [mcbd_pkg::DATA_W-1:0]  avs_readdata,
  output logic                              avs_waitrequest
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [mcbd_pkg::PC_W-1:0] sext_off(
    input logic [mcbd_pkg::OFF_W-1:0] off
  );
    sext_off = {{(mcbd_pkg::PC_W-mcbd_pkg::OFF_W){off[mcbd_pkg::OFF_W-1]}}, off};
  endfunction : sext_off

  function automatic logic core_match(
    input logic sel,
    input logic zero_act,
    input logic one_act
  );
    core_match = sel ? one_act : zero_act;
  endfunction : core_match

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [mcbd_pkg::PC_W-1:0]    pc_r;
  logic [mcbd_pkg::PC_W-1:0]    pc_nxt;
  logic                         taken_r;
  logic                         taken_nxt;
  logic                         run_r;
  logic [mcbd_pkg::CNT_W-1:0]   taken_cnt_r;
  logic [mcbd_pkg::DATA_W-1:0]  rdata_r;
  mcbd_pkg::mcbd_bus_state_t    bus_r;
  mcbd_pkg::mcbd_bus_state_t    bus_nxt;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire [mcbd_pkg::OFF_W-1:0]  off_field  = instr_word[mcbd_pkg::OFF_W-1:0];
  wire [mcbd_pkg::COND_W-1:0] cond_field =
    instr_word[mcbd_pkg::COND_LSB +: mcbd_pkg::COND_W];
  wire is_rel_cond = instr_word[15:11] == mcbd_pkg::REL_COND_OPC;
  wire is_abs_id   = (instr_word[15:5] == mcbd_pkg::ABS_ID_OPC_HI) &&
                     (instr_word[2:0] == mcbd_pkg::ABS_ID_OPC_LO);
  wire is_rel_id   = instr_word[15:6] == mcbd_pkg::REL_ID_OPC;
  wire abs_id_sel  = instr_word[mcbd_pkg::ABS_ID_SEL_BIT];
  wire jreg_sel    = instr_word[mcbd_pkg::ABS_JREG_BIT];
  wire rel_id_sel  = instr_word[mcbd_pkg::REL_ID_SEL_BIT];

  // ----------------------------------------------------------------
  // condition selection
  // ----------------------------------------------------------------
  logic [63:0] cond_vec;
  always_comb begin
    cond_vec = '0;
    cond_vec[mcbd_pkg::CC_FLAG_LOW  +: 16] = ~flags;
    cond_vec[mcbd_pkg::CC_FLAG_HIGH +: 16] = flags;
    cond_vec[mcbd_pkg::CC_TC        +: 4]  = terminal_count;
    cond_vec[mcbd_pkg::CC_START_LOW]       = ~start_in;
    cond_vec[mcbd_pkg::CC_START_HIGH]      = start_in;
    cond_vec[mcbd_pkg::CC_VDS_LOW   +: 3]  = ~shortcut_vds_high;
    cond_vec[mcbd_pkg::CC_SRC_LOW   +: 3]  = ~shortcut_src_high;
    cond_vec[mcbd_pkg::CC_VDS_HIGH  +: 3]  = shortcut_vds_high;
    cond_vec[mcbd_pkg::CC_ALU_DONE]        = alu_op_done;
    cond_vec[mcbd_pkg::CC_BOOST_HIGH]      = boost_voltage_high;
    cond_vec[mcbd_pkg::CC_BOOST_LOW]       = ~boost_voltage_high;
    cond_vec[mcbd_pkg::CC_CUR_HIGH  +: 6]  = current_fbk_high;
    cond_vec[mcbd_pkg::CC_CUR_LOW   +: 6]  = ~current_fbk_high;
    cond_vec[mcbd_pkg::CC_OWN_HIGH]        = own_current_high;
    cond_vec[mcbd_pkg::CC_OWN_LOW]         = ~own_current_high;
  end

  wire cond_true = cond_vec[cond_field];
  wire abs_match = core_match(abs_id_sel, core_zero_active, core_one_active);
  wire rel_match = core_match(rel_id_sel, core_zero_active, core_one_active);
  wire step      = instr_valid && run_r;

  wire [mcbd_pkg::PC_W-1:0] rel_target = pc_r + sext_off(off_field);
  wire [mcbd_pkg::PC_W-1:0] seq_target = pc_r + 10'h001;
  wire [mcbd_pkg::PC_W-1:0] jreg_value = jreg_sel ? jump_register_set_1
                                                  : jump_register_set_0;

  wire take_rel_cond = is_rel_cond && cond_true;
  wire take_abs_id   = is_abs_id && abs_match;
  wire take_rel_id   = is_rel_id && rel_match;
  wire take_any      = take_rel_cond || take_abs_id || take_rel_id;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire bus_req  = avs_read || avs_write;
  wire bus_done = bus_r == mcbd_pkg::MCBD_BUS_ACK;
  wire wr_ctrl  = bus_done && avs_write && (avs_address == mcbd_pkg::REG_CTRL);
  wire wr_pc    = bus_done && avs_write && (avs_address == mcbd_pkg::REG_PC);

  logic [mcbd_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    case (avs_address)
      mcbd_pkg::REG_CTRL: begin
        rd_mux = {31'h0000_0000, run_r};
      end
      mcbd_pkg::REG_PC: begin
        rd_mux = {22'h00_0000, pc_r};
      end
      mcbd_pkg::REG_STATUS: begin
        rd_mux = {15'h0000, taken_r, taken_cnt_r};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    case (bus_r)
      mcbd_pkg::MCBD_BUS_IDLE: begin
        bus_nxt = bus_req ? mcbd_pkg::MCBD_BUS_ACK : mcbd_pkg::MCBD_BUS_IDLE;
      end
      mcbd_pkg::MCBD_BUS_ACK: begin
        bus_nxt = mcbd_pkg::MCBD_BUS_IDLE;
      end
      default: begin
        bus_nxt = mcbd_pkg::MCBD_BUS_IDLE;
      end
    endcase
  end

  assign avs_waitrequest = bus_req && !bus_done;

  // ----------------------------------------------------------------
  // next program counter
  // ----------------------------------------------------------------
  always_comb begin
    pc_nxt    = pc_r;
    taken_nxt = 1'b0;
    if (wr_pc) begin
      pc_nxt = avs_writedata[mcbd_pkg::PC_W-1:0];
    end else if (step) begin
      taken_nxt = take_any;
      if (take_abs_id) begin
        pc_nxt = jreg_value;
      end else if (take_rel_cond || take_rel_id) begin
        pc_nxt = rel_target;
      end else begin
        pc_nxt = seq_target;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pc_r    <= mcbd_pkg::PC_RST;
      taken_r <= 1'b0;
    end else begin
      pc_r    <= pc_nxt;
      taken_r <= taken_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      taken_cnt_r <= 16'h0000;
    end else if (taken_nxt) begin
      taken_cnt_r <= taken_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_r <= mcbd_pkg::CTRL_RUN_RST;
    end else if (wr_ctrl) begin
      run_r <= avs_writedata[mcbd_pkg::CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_r   <= mcbd_pkg::MCBD_BUS_IDLE;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_r <= bus_nxt;
      if (!bus_done && avs_read) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign program_counter = pc_r;
  assign branch_taken    = taken_r;
  assign avs_readdata    = rdata_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  wire plain_step = step && !wr_pc;

  property p_rel_cond_target;
    plain_step && is_rel_cond && cond_true |=>
      program_counter == $past(pc_r) + sext_off($past(off_field)) && branch_taken;
  endproperty
  a_rel_cond_target: assert property (p_rel_cond_target)
    else $error("relative conditional jump went to wrong address");

  property p_offset_range;
    plain_step && is_rel_cond && cond_true |=>
      ($signed(program_counter - $past(pc_r)) >= -16) &&
      ($signed(program_counter - $past(pc_r)) <= 15);
  endproperty
  a_offset_range: assert property (p_offset_range)
    else $error("relative jump outside minus sixteen to fifteen");

  property p_not_taken;
    plain_step && !take_any |=>
      program_counter == $past(pc_r) + 10'h001 && !branch_taken;
  endproperty
  a_not_taken: assert property (p_not_taken)
    else $error("untaken jump did not step to next address");

  property p_flag_cond;
    cond_field[5] == 1'b0 |->
      cond_true == (cond_field[4] ? flags[cond_field[3:0]] : !flags[cond_field[3:0]]);
  endproperty
  a_flag_cond: assert property (p_flag_cond)
    else $error("flag condition decoded wrongly");

  property p_tc_cond;
    cond_field[5:2] == 4'h8 |-> cond_true == terminal_count[cond_field[1:0]];
  endproperty
  a_tc_cond: assert property (p_tc_cond)
    else $error("terminal count condition decoded wrongly");

  property p_start_cond;
    cond_field == 6'h25 |-> cond_true == start_in;
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("start high condition decoded wrongly");

  property p_own_cond;
    cond_field[5:1] == 5'h1F |-> cond_true == (own_current_high ^ cond_field[0]);
  endproperty
  a_own_cond: assert property (p_own_cond)
    else $error("own current feedback condition decoded wrongly");

  property p_abs_id;
    plain_step && is_abs_id && core_match(abs_id_sel, core_zero_active, core_one_active)
      |=> program_counter == $past(jreg_value);
  endproperty
  a_abs_id: assert property (p_abs_id)
    else $error("absolute identifier jump did not load jump register");

  property p_abs_id_miss;
    plain_step && is_abs_id && !abs_id_sel && !core_zero_active |=> !branch_taken;
  endproperty
  a_abs_id_miss: assert property (p_abs_id_miss)
    else $error("identifier jump taken on wrong core");

  property p_rel_id;
    plain_step && is_rel_id && (rel_id_sel ? core_one_active : core_zero_active) |=>
      program_counter == $past(pc_r) + sext_off($past(instr_word[4:0]));
  endproperty
  a_rel_id: assert property (p_rel_id)
    else $error("relative identifier jump went to wrong address");

  property p_bus_one_wait;
    bus_req && !bus_done |=> !avs_waitrequest;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait)
    else $error("bus answer later than one wait cycle");

  property p_shortcut_cond;
    (cond_field == 6'h28 |-> cond_true == !shortcut_vds_high[2]) and
    (cond_field == 6'h29 |-> cond_true == !shortcut_src_high[0]) and
    (cond_field == 6'h2E |-> cond_true == shortcut_vds_high[2]);
  endproperty
  a_shortcut_cond: assert property (p_shortcut_cond)
    else $error("shortcut feedback condition decoded wrongly");

  property p_boost_cur_cond;
    (cond_field == 6'h31 |-> cond_true == !boost_voltage_high) and
    (cond_field == 6'h32 |-> cond_true == current_fbk_high[0]) and
    (cond_field == 6'h3D |-> cond_true == !current_fbk_high[5]);
  endproperty
  a_boost_cur_cond: assert property (p_boost_cur_cond)
    else $error("boost or current feedback condition decoded wrongly");

  property p_alu_start_cond;
    (cond_field == 6'h24 |-> cond_true == !start_in) and
    (cond_field == 6'h2F |-> cond_true == alu_op_done);
  endproperty
  a_alu_start_cond: assert property (p_alu_start_cond)
    else $error("start low or arithmetic done condition decoded wrongly");

  property p_rel_id_miss;
    plain_step && is_rel_id && rel_id_sel && !core_one_active |=> !branch_taken;
  endproperty
  a_rel_id_miss: assert property (p_rel_id_miss)
    else $error("relative identifier jump taken on wrong core");

  c_rel_taken:  cover property (plain_step && take_rel_cond ##1 branch_taken);
  c_abs_taken:  cover property (plain_step && take_abs_id);
  c_rel_id:     cover property (plain_step && take_rel_id);
  c_back_jump:  cover property (plain_step && take_rel_cond && off_field[4]);

endmodule : mcbd_branch_unit

// ===== core/mcbd_pkg.sv
// constants and types shared by the conditional branch decoder
package mcbd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PC_W   = 10;
  localparam int unsigned INSN_W = 16;
  localparam int unsigned OFF_W  = 5;
  localparam int unsigned COND_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 4;

  // ----------------------------------------------------------------
  // instruction field positions and fixed patterns
  // ----------------------------------------------------------------
  localparam int unsigned        COND_LSB       = 5;
  localparam logic [4:0]         REL_COND_OPC   = 5'h00;
  localparam logic [10:0]        ABS_ID_OPC_HI  = 11'h1CC;
  localparam logic [2:0]         ABS_ID_OPC_LO  = 3'h5;
  localparam int unsigned        ABS_ID_SEL_BIT = 4;
  localparam int unsigned        ABS_JREG_BIT   = 3;
  localparam logic [9:0]         REL_ID_OPC     = 10'h0BD;
  localparam int unsigned        REL_ID_SEL_BIT = 5;

  // ----------------------------------------------------------------
  // condition code base positions in the condition vector
  // ----------------------------------------------------------------
  localparam int unsigned CC_FLAG_LOW   = 0;
  localparam int unsigned CC_FLAG_HIGH  = 16;
  localparam int unsigned CC_TC         = 32;
  localparam int unsigned CC_START_LOW  = 36;
  localparam int unsigned CC_START_HIGH = 37;
  localparam int unsigned CC_VDS_LOW    = 38;
  localparam int unsigned CC_SRC_LOW    = 41;
  localparam int unsigned CC_VDS_HIGH   = 44;
  localparam int unsigned CC_ALU_DONE   = 47;
  localparam int unsigned CC_BOOST_HIGH = 48;
  localparam int unsigned CC_BOOST_LOW  = 49;
  localparam int unsigned CC_CUR_HIGH   = 50;
  localparam int unsigned CC_CUR_LOW    = 56;
  localparam int unsigned CC_OWN_HIGH   = 62;
  localparam int unsigned CC_OWN_LOW    = 63;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PC     = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam int unsigned       CTRL_RUN_BIT   = 0;
  localparam logic              CTRL_RUN_RST   = 1'h1;
  localparam logic [PC_W-1:0]   PC_RST         = 10'h000;
  localparam int unsigned       STAT_TAKEN_BIT = 16;
  localparam int unsigned       CNT_W          = 16;

  // ----------------------------------------------------------------
  // bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCBD_BUS_IDLE = 2'h1,
    MCBD_BUS_ACK  = 2'h2
  } mcbd_bus_state_t;

endpackage : mcbd_pkg

// ===== verif/mcbd_branch_unit_tb.sv
// self-checking bench for the conditional branch decoder
`timescale 1ns/10ps
module mcbd_branch_unit_tb;
  localparam logic [9:0]  JR0  = 10'h2A5;
  localparam logic [9:0]  JR1  = 10'h15A;
  localparam logic [35:0] BASE = 36'h9A5C36E1B;

  logic        sys_clk;
  logic        nrst;
  logic        instr_valid;
  logic [35:0] src_r;
  logic [1:0]  core_r;
  logic        load_en;
  logic [9:0]  load_addr;
  logic [15:0] load_data;
  logic [15:0] instr_word;
  logic [9:0]  jreg0;
  logic [9:0]  jreg1;
  logic [9:0]  program_counter;
  logic        branch_taken;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          fails;
  int          n_tests;
  int          n_taken;
  logic [9:0]  exp_pc;
  logic        run_now;
  logic [31:0] rdata;

  mcbd_code_mem #(.JREG0(JR0), .JREG1(JR1)) u_mem (
    .sys_clk(sys_clk), .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .program_counter(program_counter), .instr_word(instr_word),
    .jump_register_set_0(jreg0), .jump_register_set_1(jreg1));

  mcbd_branch_unit u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
    .flags(src_r[15:0]), .terminal_count(src_r[19:16]), .start_in(src_r[20]),
    .shortcut_vds_high(src_r[23:21]), .shortcut_src_high(src_r[26:24]),
    .alu_op_done(src_r[27]), .boost_voltage_high(src_r[28]),
    .current_fbk_high(src_r[34:29]), .own_current_high(src_r[35]),
    .core_zero_active(core_r[0]), .core_one_active(core_r[1]),
    .jump_register_set_0(jreg0), .jump_register_set_1(jreg1),
    .program_counter(program_counter), .branch_taken(branch_taken),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_pc(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_pc

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_word

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // register bus and instruction step
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int i;
    @(posedge sys_clk);
    avs_address   <= adr;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= wd;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i == 16) begin
      fails++;
      $display("CHECK FAILED waitrequest expected 0 seen 1");
      test_done();
    end
  endtask : bus

  function automatic logic [9:0] rel(input logic [4:0] off);
    return exp_pc + {{5{off[4]}}, off};
  endfunction : rel

  // load word at the counter, present it for one step, then compare
  task automatic step(input logic [15:0] ins, input logic [35:0] s, input logic [1:0] core,
                      input logic tk, input logic [9:0] tgt);
    @(posedge sys_clk);
    load_en   <= 1'b1;
    load_addr <= program_counter;
    load_data <= ins;
    src_r     <= s;
    core_r    <= core;
    @(posedge sys_clk);
    load_en     <= 1'b0;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk_bit("branch_taken", run_now & tk, branch_taken);
    if (run_now) begin
      exp_pc = tk ? tgt : exp_pc + 10'h001;
      n_taken += int'(tk);
    end
    chk_pc("program_counter", exp_pc, program_counter);
  endtask : step

  // condition code to {inverted polarity, source index}
  function automatic logic [6:0] cmap(input logic [5:0] c);
    if (c < 6'h10) return {1'b1, c};
    if (c < 6'h24) return {1'b0, c - 6'h10};
    if (c < 6'h26) return {~c[0], 6'h14};
    if (c < 6'h2C) return {1'b1, c - 6'h11};
    if (c < 6'h2F) return {1'b0, c - 6'h17};
    if (c < 6'h31) return {1'b0, c - 6'h14};
    if (c == 6'h31) return {1'b1, 6'h1C};
    if (c < 6'h38) return {1'b0, c - 6'h15};
    if (c < 6'h3E) return {1'b1, c - 6'h1B};
    return {c[0], 6'h23};
  endfunction : cmap

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [35:0] s;
    logic [6:0]  m;
    logic [4:0]  off;
    logic [1:0]  core;
    fails = 0;
    n_tests = 0;
    n_taken = 0;
    run_now = 1'b1;
    exp_pc = 10'h000;
    nrst <= 1'b0;
    instr_valid <= 1'b0;
    src_r <= BASE;
    core_r <= 2'h1;
    load_en <= 1'b0;
    load_addr <= 10'h000;
    load_data <= 16'h0000;
    avs_address <= 4'h0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h00000000;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    bus(1'b0, mcbd_pkg::REG_PC, 32'h0);
    chk_pc("pc reset", mcbd_pkg::PC_RST, rdata[9:0]);
    bus(1'b0, mcbd_pkg::REG_CTRL, 32'h0);
    chk_bit("run reset", mcbd_pkg::CTRL_RUN_RST, rdata[0]);
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    bus(1'b0, 4'hC, 32'h0);
    chk_word("unmapped read", 32'h00000000, rdata);
    $display("test reset and registers done");

    bus(1'b1, mcbd_pkg::REG_PC, 32'h000003F0);
    exp_pc = 10'h3F0;
    for (int c = 0; c < 64; c++) begin
      for (int v = 0; v < 2; v++) begin
        m = cmap(6'(c));
        s = BASE;
        s[m[5:0]] = v[0] ^ m[6];
        off = 5'(c) ^ {4'h0, v[0]};
        step({5'h00, 6'(c), off}, s, 2'h1,
             v[0], rel(off));
      end
    end
    $display("test condition codes done");

    for (int sel = 0; sel < 2; sel++) begin
      for (int jr = 0; jr < 2; jr++) begin
        for (int act = 0; act < 3; act++) begin
          core = (act == 0) ? 2'h1 : (act == 1) ? 2'h2 : 2'h0;
          step({11'h1CC, sel[0], jr[0], 3'h5}, BASE, core,
               core[sel], jr ? JR1 : JR0);
          off = sel ? 5'h10 + 5'(act) : 5'h0F - 5'(act);
          step({10'h0BD, sel[0], off}, BASE, core,
               core[sel], rel(off));
        end
      end
    end
    $display("test core identifier jumps done");

    s = BASE | 36'h1;
    step({5'h01, 6'h10, 5'h05}, s, 2'h1, 1'b0, 10'h000);
    step({11'h1CC, 1'b0, 1'b0, 3'h4}, BASE, 2'h1, 1'b0, 10'h000);
    step({10'h0BC, 1'b0, 5'h03}, BASE, 2'h1, 1'b0, 10'h000);
    bus(1'b1, mcbd_pkg::REG_CTRL, 32'h0);
    run_now = 1'b0;
    step({5'h00, 6'h10, 5'h05}, s, 2'h1, 1'b1, 10'h000);
    bus(1'b1, mcbd_pkg::REG_CTRL, 32'h1);
    run_now = 1'b1;
    bus(1'b0, mcbd_pkg::REG_STATUS, 32'h0);
    chk_word("status", {15'h0000, 1'b0, 16'(n_taken)}, rdata);
    $display("test decode boundaries and halt done");
    test_done();
  end
endmodule : mcbd_branch_unit_tb

// ===== verif/mcbd_code_mem.sv
// code memory and jump registers on the far side of the branch decoder
`timescale 1ns/10ps
module mcbd_code_mem #(
  parameter logic [mcbd_pkg::PC_W-1:0] JREG0 = 10'h2A5,
  parameter logic [mcbd_pkg::PC_W-1:0] JREG1 = 10'h15A
) (
  input  wire logic                          sys_clk,
  input  wire logic                          load_en,
  input  wire logic [mcbd_pkg::PC_W-1:0]     load_addr,
  input  wire logic [mcbd_pkg::INSN_W-1:0]   load_data,
  input  wire logic [mcbd_pkg::PC_W-1:0]     program_counter,
  output logic      [mcbd_pkg::INSN_W-1:0]   instr_word,
  output logic      [mcbd_pkg::PC_W-1:0]     jump_register_set_0,
  output logic      [mcbd_pkg::PC_W-1:0]     jump_register_set_1
);
  logic [mcbd_pkg::INSN_W-1:0] mem_r [0:1023];

  always_ff @(posedge sys_clk) begin
    if (load_en) begin
      mem_r[load_addr] <= load_data;
    end
  end

  // fetch follows the counter with no latency
  assign instr_word          = mem_r[program_counter];
  assign jump_register_set_0 = JREG0;
  assign jump_register_set_1 = JREG1;
endmodule : mcbd_code_mem
